// file: dv/ddr4_command_timing_guard_tb_top.sv
// Self-checking bench for the DDR4 command timing guard
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end

module ddr4_command_timing_guard_tb_top;
  import dtg_pkg::*;
  // Shortened power-up wait keeps the run brief
  localparam int INIT_SIM = 20;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [4:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_code = '0;
  logic [3:0] cmd_bank = '0;
  logic [31:0] avs_rdata;
  logic avs_wait, ready, mem_valid, mem_rst_n, mem_cke;
  logic [2:0] mem_cmd;
  logic [3:0] mem_bank;
  logic [15:0] cmds, viol;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int issued = 0;
  int seed = 32'hE252F057;
  logic [2:0] last_c = CMD_NOP;
  logic [3:0] last_b = '0;

  always #12.5 i_sys_clk = ~i_sys_clk;

  dtg_guard #(.NUM_BANKS(16), .BANK_W(4), .INIT_CYC(INIT_SIM)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write),
    .i_avs_writedata(avs_writedata), .o_avs_readdata(avs_rdata), .o_avs_waitrequest(avs_wait),
    .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code), .i_cmd_bank(cmd_bank), .o_cmd_ready(ready),
    .o_mem_cmd_valid(mem_valid), .o_mem_cmd(mem_cmd), .o_mem_bank(mem_bank),
    .o_mem_reset_n(mem_rst_n), .o_mem_cke(mem_cke));

  dtg_mem_model mem (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cmd_valid(mem_valid), .i_cmd(mem_cmd),
    .i_bank(mem_bank), .i_reset_n(mem_rst_n), .i_cke(mem_cke), .o_cmds(cmds), .o_viol(viol));

  // ====
  // Helpers
  function automatic int cy(input logic [7:0] ns);
    return (ns == 8'h00) ? 1 : (int'(ns) + 24) / 25;
  endfunction

  function automatic int mx(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic avm(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    @(posedge i_sys_clk);
    while (avs_wait !== 1'b0 && n < 50)
    begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 50)
      bad_count++;
    q = avs_rdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge i_sys_clk);
  endtask

  // Valid stays up across calls so no edge sees it dropped and raised
  task automatic issue(input logic [2:0] c, input logic [3:0] b, output int t);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_bank <= b;
    @(negedge i_sys_clk);
    `CHK(mem_valid, last_c != CMD_NOP)
    `CHK(mem_cmd, last_c)
    `CHK(mem_bank, last_b)
    while (ready !== 1'b1 && n < 400)
    begin
      @(negedge i_sys_clk);
      n++;
    end
    if (n >= 400)
      bad_count++;
    @(posedge i_sys_clk);
    t = cyc;
    last_c = c;
    last_b = b;
    issued++;
  endtask

  always @(negedge i_sys_clk)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      bad_count++;
      results();
    end
  end

  // ====
  // Main sequence
  initial
  begin
    logic [31:0] q, d;
    logic [7:0] s [5];
    logic [7:0] rv [5];
    logic [3:0] b;
    int n, t0, t1, t2;
    rv = '{RST_MODE_SET, RST_ACT_PRE, RST_ACT_COL, RST_PRE_PER, RST_WR_REC};
    repeat (10) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    for (int i = 0; i < 5; i++)
    begin
      avm(1'b0, REG_MODE_SET + 5'(4 * i), 32'h0, q);
      `CHK(q, {24'h0, rv[i]})
    end
    avm(1'b0, 5'h02, 32'h0, q);
    `CHK(q, 32'h0)
    avm(1'b0, REG_BANK_RDY, 32'h0, q);
    `CHK(q, 32'h0000_FFFF)
    `CHK(mem_rst_n, 1'b0)
    avm(1'b1, REG_CTRL, 32'h1, q);
    n = 0;
    @(negedge i_sys_clk);
    while (mem_cke !== 1'b1 && n < 100)
    begin
      `CHK(ready, 1'b0)
      @(negedge i_sys_clk);
      n++;
    end
    // Memory reset rises on the edge the write task returns at; enable follows INIT_SIM+1 edges later
    `CHK(n, INIT_SIM + 1)
    `CHK(mem_rst_n, 1'b1)
    @(posedge i_sys_clk);
    avm(1'b0, REG_STATUS, 32'h0, q);
    `CHK(q[2:0], 3'h7)
    for (int k = 0; k < 12; k++)
    begin
      if (k == 0)
        s = '{8'h01, 8'h00, 8'h19, 8'h1A, 8'h32};
      else if (k == 1)
        s = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
      // Spacings that the exact-count checks in the design look for
      else if (k == 2)
        s = '{8'h04, 8'h3C, 8'h32, 8'h32, 8'h19};
      else
        for (int i = 0; i < 5; i++)
          s[i] = 8'($random(seed)) | ((i == 0) ? 8'h01 : 8'h00);
      for (int i = 0; i < 5; i++)
      begin
        d = $random(seed);
        d[7:0] = s[i];
        avm(1'b1, REG_MODE_SET + 5'(4 * i), d, q);
        avm(1'b0, REG_MODE_SET + 5'(4 * i), 32'h0, q);
        `CHK(q, {24'h0, s[i]})
      end
      b = 4'($random(seed));
      issue(CMD_MRS, b, t0);
      issue(CMD_MRS, b, t1);
      `CHK(t1 - t0, int'(s[0]))
      issue(CMD_ACT, b, t0);
      issue(CMD_WR, b, t1);
      `CHK(t1 - t0, cy(s[2]))
      issue(CMD_PRE, b, t2);
      `CHK(t2 - t1, mx(cy(s[1]) - (t1 - t0), cy(s[4])))
      issue(CMD_ACT, b, t0);
      `CHK(t0 - t2, cy(s[3]))
      issue(CMD_RD, b, t1);
      `CHK(t1 - t0, cy(s[2]))
      issue(CMD_PRE, b, t2);
      `CHK(t2 - t1, mx(cy(s[1]) - (t1 - t0), 1))
      cmd_valid <= 1'b0;
      @(negedge i_sys_clk);
      `CHK(mem_valid, 1'b1)
      `CHK(mem_cmd, CMD_PRE)
      @(posedge i_sys_clk);
      last_c = CMD_NOP;
    end
    // Clearing the release bit puts the memory back in reset and drops clock enable
    avm(1'b1, REG_CTRL, 32'h0, q);
    repeat (2) @(negedge i_sys_clk);
    `CHK(mem_rst_n, 1'b0)
    `CHK(mem_cke, 1'b0)
    `CHK(ready, 1'b0)
    repeat (2) @(posedge i_sys_clk);
    `CHK(viol, 16'h0000)
    `CHK(cmds, 16'(issued))
    results();
  end
endmodule // ddr4_command_timing_guard_tb_top

`default_nettype wire

// file: dv/dtg_mem_model.sv
// Passive DDR4 device model that counts commands and protocol slips
`timescale 1ns/10ps
`default_nettype none

module dtg_mem_model
  import dtg_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Command pins
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd,
  input wire logic [3:0] i_bank,
  input wire logic i_reset_n,
  input wire logic i_cke,
  // Counters
  output logic [15:0] o_cmds,
  output logic [15:0] o_viol
);
  // ====
  // Open rows, one bit per bank
  logic [15:0] open_row;
  logic bad_now;

  assign bad_now = !i_cke || !i_reset_n
    || ((i_cmd == CMD_RD || i_cmd == CMD_WR) && !open_row[i_bank]);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_cmds <= '0;
      o_viol <= '0;
      open_row <= '0;
    end
    else if (i_cmd_valid)
    begin
      o_cmds <= o_cmds + 16'h0001;
      o_viol <= o_viol + 16'(bad_now);
      if (i_cmd == CMD_ACT)
        open_row[i_bank] <= 1'b1;
      if (i_cmd == CMD_PRE)
        open_row[i_bank] <= 1'b0;
    end
  end
endmodule // dtg_mem_model

`default_nettype wire

// file: rtl/dtg_bank_timer.sv
// Per-bank spacing counters for activate, column, precharge and write recovery
`timescale 1ns/10ps
`default_nettype none

module dtg_bank_timer
  import dtg_pkg::*;
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Command strobes for this bank
  input wire logic i_act,
  input wire logic i_pre,
  input wire logic i_wr,
  // Spacings in cycles
  input wire logic [CYC_W-1:0] i_act_pre_cyc,
  input wire logic [CYC_W-1:0] i_act_col_cyc,
  input wire logic [CYC_W-1:0] i_pre_per_cyc,
  input wire logic [CYC_W-1:0] i_wr_rec_cyc,
  // Permissions
  output logic o_act_ok,
  output logic o_col_ok,
  output logic o_pre_ok
);

  // ==========================================================================
  // Counters load spacing minus one so the dependent command may go exactly
  // spacing cycles after its cause
  logic [CYC_W-1:0] ras_cnt;
  logic [CYC_W-1:0] rcd_cnt;
  logic [CYC_W-1:0] rp_cnt;
  logic [CYC_W-1:0] wr_cnt;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ras_cnt <= '0;
      rcd_cnt <= '0;
      rp_cnt <= '0;
      wr_cnt <= '0;
    end
    else
    begin
      ras_cnt <= i_act ? i_act_pre_cyc - 1'b1 : (ras_cnt != '0 ? ras_cnt - 1'b1 : ras_cnt);
      rcd_cnt <= i_act ? i_act_col_cyc - 1'b1 : (rcd_cnt != '0 ? rcd_cnt - 1'b1 : rcd_cnt);
      rp_cnt <= i_pre ? i_pre_per_cyc - 1'b1 : (rp_cnt != '0 ? rp_cnt - 1'b1 : rp_cnt);
      wr_cnt <= i_wr ? i_wr_rec_cyc - 1'b1 : (wr_cnt != '0 ? wr_cnt - 1'b1 : wr_cnt);
    end
  end

  assign o_act_ok = (rp_cnt == '0);
  assign o_col_ok = (rcd_cnt == '0);
  assign o_pre_ok = (ras_cnt == '0) && (wr_cnt == '0);

  // ==========================================================================
  // Checks
  a_pre_after_act: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_act && i_act_pre_cyc == 8'h03 |=> !o_pre_ok ##1 !o_pre_ok)
    else $error("precharge allowed before activate-to-precharge time");
  a_col_after_act: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_act && i_act_col_cyc > 8'h01 |=> !o_col_ok)
    else $error("column access allowed too soon after activate");
  a_act_after_pre: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_pre && i_pre_per_cyc == 8'h02 |=> !o_act_ok ##1 o_act_ok)
    else $error("precharge period not kept exactly");
  a_pre_after_wr: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_wr && i_wr_rec_cyc > 8'h01 |=> !o_pre_ok)
    else $error("precharge allowed during write recovery");

endmodule // dtg_bank_timer

`default_nettype wire

// file: rtl/dtg_guard.sv
// DDR4 command timing guard with Avalon-MM settings registers
`timescale 1ns/10ps
`default_nettype none

module dtg_guard
  import dtg_pkg::*;
#(
  parameter int unsigned NUM_BANKS = 16,
  parameter int unsigned BANK_W = 4,
  parameter int unsigned INIT_CYC = INIT_WAIT_CYC
)
(
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Command request from the controller
  input wire logic i_cmd_valid,
  input wire logic [2:0] i_cmd_code,
  input wire logic [BANK_W-1:0] i_cmd_bank,
  output logic o_cmd_ready,
  // Command to the memory
  output logic o_mem_cmd_valid,
  output logic [2:0] o_mem_cmd,
  output logic [BANK_W-1:0] o_mem_bank,
  output logic o_mem_reset_n,
  output logic o_mem_cke
);

  // ==========================================================================
  // Register bus: one wait cycle, answer on the second edge
  logic ack;
  logic reset_release;
  logic [CYC_W-1:0] mode_set_spacing_setting;
  logic [CYC_W-1:0] act_to_pre_setting;
  logic [CYC_W-1:0] act_to_col_setting;
  logic [CYC_W-1:0] pre_period_setting;
  logic [CYC_W-1:0] write_recovery_setting;
  logic init_done;
  logic [NUM_BANKS-1:0] act_ok;
  logic [NUM_BANKS-1:0] col_ok;
  logic [NUM_BANKS-1:0] pre_ok;

  wire bus_req = i_avs_read | i_avs_write;
  wire wr_hit = i_avs_write & ack;
  wire [31:0] rd_mux =
    (i_avs_address == REG_CTRL) ? 32'(reset_release) :
    (i_avs_address == REG_STATUS) ? 32'({init_done, o_mem_cke, o_mem_reset_n}) :
    (i_avs_address == REG_MODE_SET) ? 32'(mode_set_spacing_setting) :
    (i_avs_address == REG_ACT_PRE) ? 32'(act_to_pre_setting) :
    (i_avs_address == REG_ACT_COL) ? 32'(act_to_col_setting) :
    (i_avs_address == REG_PRE_PER) ? 32'(pre_period_setting) :
    (i_avs_address == REG_WR_REC) ? 32'(write_recovery_setting) :
    (i_avs_address == REG_BANK_RDY) ? 32'(act_ok) : 32'h0000_0000;

  assign o_avs_waitrequest = bus_req & ~ack;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ack <= 1'b0;
      o_avs_readdata <= 32'h0000_0000;
    end
    else
    begin
      ack <= bus_req & ~ack;
      if (i_avs_read & ~ack)
        o_avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      reset_release <= 1'b0;
      mode_set_spacing_setting <= RST_MODE_SET;
      act_to_pre_setting <= RST_ACT_PRE;
      act_to_col_setting <= RST_ACT_COL;
      pre_period_setting <= RST_PRE_PER;
      write_recovery_setting <= RST_WR_REC;
    end
    else if (wr_hit)
    begin
      if (i_avs_address == REG_CTRL)
        reset_release <= i_avs_writedata[CTRL_RESET_RELEASE];
      if (i_avs_address == REG_MODE_SET)
        mode_set_spacing_setting <= i_avs_writedata[CYC_W-1:0];
      if (i_avs_address == REG_ACT_PRE)
        act_to_pre_setting <= i_avs_writedata[CYC_W-1:0];
      if (i_avs_address == REG_ACT_COL)
        act_to_col_setting <= i_avs_writedata[CYC_W-1:0];
      if (i_avs_address == REG_PRE_PER)
        pre_period_setting <= i_avs_writedata[CYC_W-1:0];
      if (i_avs_address == REG_WR_REC)
        write_recovery_setting <= i_avs_writedata[CYC_W-1:0];
    end
  end

  // ==========================================================================
  // Cycle counts derived from nanosecond settings, registered to keep the
  // divider off the command path
  logic [CYC_W-1:0] act_pre_cyc;
  logic [CYC_W-1:0] act_col_cyc;
  logic [CYC_W-1:0] pre_per_cyc;
  logic [CYC_W-1:0] wr_rec_cyc;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      act_pre_cyc <= ns_to_cyc(RST_ACT_PRE);
      act_col_cyc <= ns_to_cyc(RST_ACT_COL);
      pre_per_cyc <= ns_to_cyc(RST_PRE_PER);
      wr_rec_cyc <= ns_to_cyc(RST_WR_REC);
    end
    else
    begin
      act_pre_cyc <= ns_to_cyc(act_to_pre_setting);
      act_col_cyc <= ns_to_cyc(act_to_col_setting);
      pre_per_cyc <= ns_to_cyc(pre_period_setting);
      wr_rec_cyc <= ns_to_cyc(write_recovery_setting);
    end
  end

  // ==========================================================================
  // Power-up: memory reset follows software, clock enable waits the init time
  logic [INIT_W-1:0] init_cnt;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_mem_reset_n <= 1'b0;
      init_cnt <= '0;
      init_done <= 1'b0;
      o_mem_cke <= 1'b0;
    end
    else
    begin
      o_mem_reset_n <= reset_release;
      if (!o_mem_reset_n)
      begin
        init_cnt <= '0;
        init_done <= 1'b0;
      end
      else if (init_cnt == INIT_W'(INIT_CYC - 1))
        init_done <= 1'b1;
      else
        init_cnt <= init_cnt + 1'b1;
      o_mem_cke <= init_done & o_mem_reset_n;
    end
  end

  // ==========================================================================
  // Command gating
  logic [CYC_W-1:0] mrs_cnt;
  wire mrs_ok = (mrs_cnt == '0);
  wire is_mrs = (i_cmd_code == CMD_MRS);
  wire is_act = (i_cmd_code == CMD_ACT);
  wire is_pre = (i_cmd_code == CMD_PRE);
  wire is_col = (i_cmd_code == CMD_RD) || (i_cmd_code == CMD_WR);
  wire cmd_allowed =
    is_mrs ? mrs_ok :
    is_act ? act_ok[i_cmd_bank] :
    is_pre ? pre_ok[i_cmd_bank] :
    is_col ? col_ok[i_cmd_bank] :
    (i_cmd_code == CMD_NOP);
  wire issue = i_cmd_valid & o_cmd_ready;

  assign o_cmd_ready = o_mem_cke & cmd_allowed;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      mrs_cnt <= '0;
    else if (issue & is_mrs)
      mrs_cnt <= mode_set_spacing_setting - 1'b1;
    else if (mrs_cnt != '0)
      mrs_cnt <= mrs_cnt - 1'b1;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      o_mem_cmd_valid <= 1'b0;
      o_mem_cmd <= CMD_NOP;
      o_mem_bank <= '0;
    end
    else
    begin
      o_mem_cmd_valid <= issue;
      o_mem_cmd <= issue ? i_cmd_code : CMD_NOP;
      o_mem_bank <= issue ? i_cmd_bank : o_mem_bank;
    end
  end

  // ==========================================================================
  // Per-bank timers
  for (genvar b = 0; b < NUM_BANKS; b++)
  begin : g_bank
    wire sel = issue && (i_cmd_bank == BANK_W'(b));
    dtg_bank_timer u_timer (
      .i_sys_clk (i_sys_clk),
      .i_rst_n (i_rst_n),
      .i_act (sel && is_act),
      .i_pre (sel && is_pre),
      .i_wr (sel && (i_cmd_code == CMD_WR)),
      .i_act_pre_cyc (act_pre_cyc),
      .i_act_col_cyc (act_col_cyc),
      .i_pre_per_cyc (pre_per_cyc),
      .i_wr_rec_cyc (wr_rec_cyc),
      .o_act_ok (act_ok[b]),
      .o_col_ok (col_ok[b]),
      .o_pre_ok (pre_ok[b])
    );
  end

  // ==========================================================================
  // Checks
  a_cke_init_wait: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_mem_cke) |-> o_mem_reset_n && $past(init_cnt) == INIT_W'(INIT_CYC - 1))
    else $error("clock enable rose before the init wait ended");
  a_cke_low_reset: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $rose(o_mem_reset_n) |-> !o_mem_cke [*8])
    else $error("clock enable rose right after memory reset release");
  a_mrs_spacing: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    issue && is_mrs && mode_set_spacing_setting == 8'h04 |=> !mrs_ok [*3] ##1 mrs_ok)
    else $error("mode set spacing not kept exactly");
  a_issue_gated: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_mem_cmd_valid && o_mem_cmd == CMD_ACT |-> $past(act_ok[i_cmd_bank]) && $past(o_mem_cke))
    else $error("activate issued while its bank was blocked");
  a_no_cmd_before_cke: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_mem_cke |-> ##1 !o_mem_cmd_valid)
    else $error("command issued while clock enable was low");

  c_mrs_issued: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_mem_cmd_valid && o_mem_cmd == CMD_MRS);
  c_act_then_rd: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_mem_cmd == CMD_ACT ##[1:20] o_mem_cmd == CMD_RD);
  c_wr_then_pre: cover property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_mem_cmd == CMD_WR ##[1:20] o_mem_cmd == CMD_PRE);

endmodule // dtg_guard

`default_nettype wire

// file: rtl/dtg_pkg.sv
// Constants, register map and command codes for the DDR4 command timing guard
package dtg_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 40;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned INIT_WAIT_US = 500;
  localparam int unsigned INIT_WAIT_CYC = INIT_WAIT_US * CLK_MHZ;
  localparam int unsigned CYC_W = 8;
  localparam int unsigned INIT_W = 20;

  // ==========================================================================
  // Register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_MODE_SET = 5'h08;
  localparam logic [4:0] REG_ACT_PRE = 5'h0C;
  localparam logic [4:0] REG_ACT_COL = 5'h10;
  localparam logic [4:0] REG_PRE_PER = 5'h14;
  localparam logic [4:0] REG_WR_REC = 5'h18;
  localparam logic [4:0] REG_BANK_RDY = 5'h1C;

  // Field positions
  localparam int unsigned CTRL_RESET_RELEASE = 0;
  localparam int unsigned STAT_RESET_RELEASED = 0;
  localparam int unsigned STAT_CKE = 1;
  localparam int unsigned STAT_INIT_DONE = 2;

  // Reset values of the settings (cycles for mode set, ns for the rest)
  localparam logic [CYC_W-1:0] RST_MODE_SET = 8'h08;
  localparam logic [CYC_W-1:0] RST_ACT_PRE = 8'h20;
  localparam logic [CYC_W-1:0] RST_ACT_COL = 8'h0E;
  localparam logic [CYC_W-1:0] RST_PRE_PER = 8'h0E;
  localparam logic [CYC_W-1:0] RST_WR_REC = 8'h0F;

  // ==========================================================================
  // Memory commands
  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_MRS = 3'b001,
    CMD_ACT = 3'b010,
    CMD_PRE = 3'b011,
    CMD_RD = 3'b100,
    CMD_WR = 3'b101
  } dtg_cmd_t;

  // Whole cycles from nanoseconds, rounded up, never below one
  function automatic logic [CYC_W-1:0] ns_to_cyc(input logic [CYC_W-1:0] ns);
    logic [CYC_W:0] sum;
    sum = {1'b0, ns} + (CYC_W+1)'(CLK_PERIOD_NS - 1);
    ns_to_cyc = (ns == '0) ? CYC_W'(1) : CYC_W'(sum / (CYC_W+1)'(CLK_PERIOD_NS));
  endfunction

endpackage
